// [design/rcms_top.v]
// The placing of the registers and the Avalon-MM register port were decided locally.
`include "rcms_defines.vh"
module rcms_top #(
  parameter DEPTH = 8
) (
  input wire clk_sys_in,
  input wire sys_rst_in,
  input wire ce_in,
  input wire [2:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  input wire cmd_valid_in,
  input wire [7:0] cmd_data_in,
  output reg cmd_ready_out,
  output reg rsp_valid_out,
  output reg [7:0] rsp_data_out,
  input wire rsp_ready_in,
  input wire byte_tick_in,
  input wire ser_valid_in,
  input wire [7:0] ser_data_in,
  output reg ser_ready_out,
  output reg air_valid_out,
  output reg [7:0] air_data_out,
  output reg air_sof_out,
  output reg air_eof_out,
  input wire air_ready_in,
  input wire rx_valid_in,
  input wire [15:0] rx_dest_in,
  output reg rx_accept_out,
  output reg [2:0] mode_out,
  output reg fec_on_out,
  output reg echk_on_out,
  output reg crc_on_out,
  output reg [15:0] link_rate_out
);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function [15:0] rate_of;
    input [2:0] m;
    input wide;
    begin
      case (m)
        `RCMS_MODE_4FSK: rate_of = wide ? `RCMS_RATE_19200
                                        : `RCMS_RATE_9600;
        `RCMS_MODE_GMSK, `RCMS_MODE_TT_FIT:
          rate_of = wide ? `RCMS_RATE_9600 : `RCMS_RATE_4800;
        default: rate_of = `RCMS_RATE_NONE;
      endcase
    end
  endfunction
  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [2:0] mode_q;
  reg [15:0] tx_addr_q;
  reg [15:0] rx_addr_q;
  reg [7:0] gap_q;
  reg [6:0] ctrl_q;
  reg [2:0] st_q;
  reg [7:0] last_q;
  reg [2:0] code_q;
  reg code_ok_q;
  reg [2:0] rsp_idx_q;
  reg [2:0] rsp_kind_q;
  reg [7:0] gap_cnt_q;
  reg in_msg_q;
  reg [1:0] hdr_q;
  wire compat = (mode_q != `RCMS_MODE_NATIVE);
  wire tt_fit = (mode_q == `RCMS_MODE_TT_FIT);
  wire txa_eff = ctrl_q[`RCMS_CTRL_TXA] && !tt_fit;
  wire rxa_eff = ctrl_q[`RCMS_CTRL_RXA] && !tt_fit;
  // --------------------------------------------------------------------
  // Avalon slave, one wait state
  // --------------------------------------------------------------------
  wire acc = (avs_read_in || avs_write_in) && avs_waitrequest_out;
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
      tx_addr_q <= `RCMS_TX_ADDR_RST;
      rx_addr_q <= `RCMS_RX_ADDR_RST;
      gap_q <= `RCMS_GAP_RST;
      ctrl_q <= 7'h00;
    end else if (ce_in) begin
      avs_waitrequest_out <= !acc;
      if (avs_write_in && !avs_waitrequest_out) begin
        case (avs_address_in)
          `RCMS_REG_CTRL: ctrl_q <= avs_writedata_in[6:0];
          `RCMS_REG_TXADDR: tx_addr_q <= avs_writedata_in[15:0];
          `RCMS_REG_RXADDR: rx_addr_q <= avs_writedata_in[15:0];
          `RCMS_REG_GAP: gap_q <= avs_writedata_in[7:0];
          default: ;
        endcase
      end
      if (acc && avs_read_in) begin
        case (avs_address_in)
          `RCMS_REG_CTRL: avs_readdata_out <= {25'h0, ctrl_q};
          `RCMS_REG_STAT: avs_readdata_out <= {26'h0, crc_on_out,
            echk_on_out, fec_on_out, mode_q};
          `RCMS_REG_TXADDR: avs_readdata_out <= {16'h0, tx_addr_q};
          `RCMS_REG_RXADDR: avs_readdata_out <= {16'h0, rx_addr_q};
          `RCMS_REG_GAP: avs_readdata_out <= {24'h0, gap_q};
          `RCMS_REG_RATE: avs_readdata_out <= {16'h0, link_rate_out};
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end
  // --------------------------------------------------------------------
  // Command interpreter
  // --------------------------------------------------------------------
  localparam S_IDLE = 3'b001;
  localparam S_ARG = 3'b010;
  localparam S_RSP = 3'b100;
  localparam K_OK = 3'd0;
  localparam K_ERR = 3'd1;
  localparam K_DIG = 3'd2;
  reg [7:0] rsp_ch;
  reg rsp_last;
  always @* begin
    rsp_ch = `RCMS_CH_CR;
    rsp_last = 1'b0;
    case (rsp_kind_q)
      K_OK: begin
        rsp_ch = (rsp_idx_q == 3'd0) ? `RCMS_CH_O
               : (rsp_idx_q == 3'd1) ? `RCMS_CH_K : `RCMS_CH_CR;
        rsp_last = (rsp_idx_q == 3'd2);
      end
      K_ERR: begin
        rsp_ch = (rsp_idx_q == 3'd0) ? `RCMS_CH_E
               : (rsp_idx_q == 3'd3) ? `RCMS_CH_O
               : (rsp_idx_q == 3'd5) ? `RCMS_CH_CR : `RCMS_CH_R;
        rsp_last = (rsp_idx_q == 3'd5);
      end
      default: begin
        rsp_ch = (rsp_idx_q == 3'd0) ? (`RCMS_CH_ZERO | {5'h0, mode_q})
                                     : `RCMS_CH_CR;
        rsp_last = (rsp_idx_q == 3'd1);
      end
    endcase
  end
  wire cmd_take = cmd_valid_in && cmd_ready_out;
  wire rsp_go = !rsp_valid_out || rsp_ready_in;
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st_q <= S_IDLE;
      mode_q <= `RCMS_MODE_NATIVE;
      last_q <= 8'h00;
      code_q <= 3'h0;
      code_ok_q <= 1'b0;
      rsp_idx_q <= 3'h0;
      rsp_kind_q <= K_OK;
      cmd_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 8'h00;
    end else if (ce_in) begin
      if (rsp_valid_out && rsp_ready_in) begin
        rsp_valid_out <= 1'b0;
      end
      case (st_q)
        S_IDLE: begin
          cmd_ready_out <= !(rsp_valid_out && !rsp_ready_in);
          if (cmd_take) begin
            last_q <= cmd_data_in;
            if (cmd_data_in == `RCMS_CH_SET) begin
              st_q <= S_ARG;
            end else if (cmd_data_in == `RCMS_CH_QRY) begin
              rsp_kind_q <= K_DIG;
              rsp_idx_q <= 3'h0;
              cmd_ready_out <= 1'b0;
              st_q <= S_RSP;
            end
          end
        end
        S_ARG: begin
          if (cmd_take) begin
            code_q <= cmd_data_in[2:0];
            code_ok_q <= (cmd_data_in[7:3] == 5'h06) &&
                         (cmd_data_in[2:0] <= `RCMS_MODE_MAX);
            if (cmd_data_in == `RCMS_CH_CR) begin
              cmd_ready_out <= 1'b0;
              rsp_idx_q <= 3'h0;
              st_q <= S_RSP;
              if (code_ok_q && last_q != `RCMS_CH_SET) begin
                mode_q <= code_q;
                rsp_kind_q <= K_OK;
              end else begin
                rsp_kind_q <= K_ERR;
              end
            end
            last_q <= cmd_data_in;
          end
        end
        S_RSP: begin
          if (rsp_go) begin
            rsp_valid_out <= 1'b1;
            rsp_data_out <= rsp_ch;
            rsp_idx_q <= rsp_idx_q + 3'h1;
            if (rsp_last) begin
              st_q <= S_IDLE;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  // --------------------------------------------------------------------
  // Mode dependent settings
  // --------------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      mode_out <= `RCMS_MODE_NATIVE;
      fec_on_out <= 1'b0;
      echk_on_out <= 1'b0;
      crc_on_out <= 1'b0;
      link_rate_out <= `RCMS_RATE_NONE;
    end else if (ce_in) begin
      mode_out <= mode_q;
      fec_on_out <= ctrl_q[`RCMS_CTRL_FEC] && !tt_fit;
      echk_on_out <= ctrl_q[`RCMS_CTRL_ECHK] && !compat;
      crc_on_out <= ctrl_q[`RCMS_CTRL_CRC] && !compat;
      link_rate_out <= rate_of(mode_q, ctrl_q[`RCMS_CTRL_WIDE]);
    end
  end
  // --------------------------------------------------------------------
  // Receive filter
  // --------------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rx_accept_out <= 1'b0;
    end else if (ce_in) begin
      rx_accept_out <= rx_valid_in && (!rxa_eff ||
        rx_dest_in == rx_addr_q || rx_dest_in == `RCMS_BCAST_ADDR);
    end
  end
  // --------------------------------------------------------------------
  // Transmit path: FIFO, gap end detection, address header
  // --------------------------------------------------------------------
  wire f_in_rdy;
  wire f_out_vld;
  wire [7:0] f_out_dat;
  wire ser_take = ser_valid_in && ser_ready_out;
  wire air_go = !air_valid_out || air_ready_in;
  wire send_hdr = txa_eff && f_out_vld && !in_msg_q;
  wire f_pop = air_go && f_out_vld && !send_hdr && hdr_q == 2'd0;
  rcms_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(3)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .in_valid_in(ser_take),
    .in_ready_out(f_in_rdy),
    .in_data_in(ser_data_in),
    .out_valid_out(f_out_vld),
    .out_ready_in(f_pop),
    .out_data_out(f_out_dat)
  );
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ser_ready_out <= 1'b0;
      air_valid_out <= 1'b0;
      air_data_out <= 8'h00;
      air_sof_out <= 1'b0;
      air_eof_out <= 1'b0;
      gap_cnt_q <= 8'h00;
      in_msg_q <= 1'b0;
      hdr_q <= 2'd0;
    end else if (ce_in) begin
      ser_ready_out <= f_in_rdy && !ser_take;
      if (air_valid_out && air_ready_in) begin
        air_valid_out <= 1'b0;
        air_sof_out <= 1'b0;
        air_eof_out <= 1'b0;
      end
      if (ser_take) begin
        gap_cnt_q <= 8'h00;
      end else if (byte_tick_in && in_msg_q && gap_cnt_q != gap_q) begin
        gap_cnt_q <= gap_cnt_q + 8'h01;
      end
      if (send_hdr && air_go && hdr_q == 2'd0) begin
        air_valid_out <= 1'b1;
        air_sof_out <= 1'b1;
        air_data_out <= tx_addr_q[15:8];
        hdr_q <= 2'd1;
        in_msg_q <= 1'b1;
      end else if (hdr_q == 2'd1 && air_go) begin
        air_valid_out <= 1'b1;
        air_data_out <= tx_addr_q[7:0];
        hdr_q <= 2'd0;
      end else if (f_pop) begin
        air_valid_out <= 1'b1;
        air_data_out <= f_out_dat;
        air_sof_out <= !in_msg_q;
        in_msg_q <= 1'b1;
      end else if (in_msg_q && !f_out_vld && gap_cnt_q == gap_q &&
                   air_go) begin
        air_valid_out <= 1'b1;
        air_eof_out <= 1'b1;
        air_data_out <= 8'h00;
        in_msg_q <= 1'b0;
        gap_cnt_q <= 8'h00;
      end
    end
  end
endmodule // rcms_top

// [design/rcms_defines.vh]
`ifndef RCMS_DEFINES_VH
`define RCMS_DEFINES_VH
// ----------------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------------
`define RCMS_CH_SET 8'h3d
`define RCMS_CH_QRY 8'h3f
`define RCMS_CH_ZERO 8'h30
`define RCMS_CH_CR 8'h0d
`define RCMS_CH_O 8'h4f
`define RCMS_CH_K 8'h4b
`define RCMS_CH_E 8'h45
`define RCMS_CH_R 8'h52
// ----------------------------------------------------------------------
// Modes
// ----------------------------------------------------------------------
`define RCMS_MODE_NATIVE 3'h0
`define RCMS_MODE_4FSK 3'h1
`define RCMS_MODE_GMSK 3'h2
`define RCMS_MODE_TT_FIT 3'h3
`define RCMS_MODE_TT_OWN 3'h4
`define RCMS_MODE_FST 3'h5
`define RCMS_MODE_MAX 3'h5
// ----------------------------------------------------------------------
// Addresses and reset values
// ----------------------------------------------------------------------
`define RCMS_TX_ADDR_RST 16'h00ff
`define RCMS_RX_ADDR_RST 16'h0000
`define RCMS_BCAST_ADDR 16'h00ff
// ----------------------------------------------------------------------
// Air link rates in bps
// ----------------------------------------------------------------------
`define RCMS_RATE_4800 16'h12c0
`define RCMS_RATE_9600 16'h2580
`define RCMS_RATE_19200 16'h4b00
`define RCMS_RATE_NONE 16'h0000
// ----------------------------------------------------------------------
// Avalon register offsets (word index), fields
// ----------------------------------------------------------------------
`define RCMS_REG_CTRL 3'h0
`define RCMS_REG_STAT 3'h1
`define RCMS_REG_TXADDR 3'h2
`define RCMS_REG_RXADDR 3'h3
`define RCMS_REG_GAP 3'h4
`define RCMS_REG_RATE 3'h5
`define RCMS_CTRL_TXA 0
`define RCMS_CTRL_RXA 1
`define RCMS_CTRL_FEC 2
`define RCMS_CTRL_ECHK 3
`define RCMS_CTRL_CRC 4
`define RCMS_CTRL_TXPRI 5
`define RCMS_CTRL_WIDE 6
`define RCMS_GAP_RST 8'h03
`endif

// [design/rcms_fifo.v]
// ----------------------------------------------------------------------
// Byte FIFO
// ----------------------------------------------------------------------
module rcms_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_sys_in,
  input wire sys_rst_in,
  input wire ce_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push = ce_in && in_valid_in && (cnt_q != DEPTH);
  wire pop = ce_in && out_ready_in && (cnt_q != 0);
  assign in_ready_out = (cnt_q != DEPTH);
  assign out_valid_out = (cnt_q != 0);
  assign out_data_out = mem[rd_q];
  always @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end
  always @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // rcms_fifo

// [testbench/rcms_sva.sv]
// ----
// Mode, filter, reply and air framing checks
// ----
module rcms_sva (
  input logic clk_sys_in,
  input logic sys_rst_in,
  input logic ce_in,
  input logic rx_valid_in,
  input logic [15:0] rx_dest_in,
  input logic rx_accept_out,
  input logic rsp_ready_in,
  input logic rsp_valid_out,
  input logic [7:0] rsp_data_out,
  input logic cmd_ready_out,
  input logic air_valid_out,
  input logic [7:0] air_data_out,
  input logic air_sof_out,
  input logic air_eof_out,
  input logic [2:0] mode_out,
  input logic fec_on_out,
  input logic echk_on_out,
  input logic crc_on_out,
  input logic [15:0] link_rate_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  AST_MODE_RANGE: assert property (mode_out <= 3'h5)
    else $error("mode code out of range");
  AST_RX_BCAST: assert property (ce_in && rx_valid_in &&
    rx_dest_in == 16'h00ff |=> rx_accept_out)
    else $error("broadcast frame refused");
  AST_RX_IDLE: assert property (ce_in && !rx_valid_in |=>
    !rx_accept_out) else $error("accept without frame");
  AST_COMPAT_CHK: assert property (mode_out != 3'h0 |->
    !echk_on_out && !crc_on_out) else $error("checks on in compat");
  AST_FEC_SUSP: assert property (mode_out == 3'h3 |-> !fec_on_out)
    else $error("correction on in mode 3");
  AST_RATE_GMSK: assert property (mode_out inside {3'h2, 3'h3} |->
    link_rate_out inside {16'h2580, 16'h12c0})
    else $error("bad rate in gmsk mode");
  AST_RATE_4FSK: assert property (mode_out == 3'h1 |->
    link_rate_out inside {16'h4b00, 16'h2580})
    else $error("bad rate in fsk mode");
  AST_RSP_HOLD: assert property (ce_in && rsp_valid_out &&
    !rsp_ready_in |=> rsp_valid_out && $stable(rsp_data_out))
    else $error("reply byte dropped");
  AST_CMD_BUSY: assert property (rsp_valid_out |-> !cmd_ready_out)
    else $error("command taken while replying");
  AST_EOF_BEAT: assert property (air_valid_out && air_eof_out |->
    air_data_out == 8'h00 && !air_sof_out)
    else $error("bad end beat");
  cover property (mode_out == 3'h3);
  cover property (rx_valid_in && rx_dest_in == 16'h00ff);
  cover property (air_valid_out && air_eof_out);
endmodule // rcms_sva

// [testbench/rcms_remote_model.sv]
// ----
// Remote modem on the air side
// ----
module rcms_remote_model #(
  parameter logic [15:0] LOCAL = 16'h0042
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic stall_in,
  input wire logic slow_in,
  input wire logic air_valid_in,
  input wire logic [7:0] air_data_in,
  input wire logic air_sof_in,
  input wire logic air_eof_in,
  output logic air_ready_out,
  output logic [7:0] frames_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] dest_q;
  logic [1:0] cnt_q;
  logic tgl_q;
  // Transparent beats only, own correction on, no security code
  assign air_ready_out = !stall_in && (!slow_in || tgl_q);
  always @(posedge clk_sys_in) begin
    tgl_q <= !tgl_q && !sys_rst_in;
    if (sys_rst_in) begin
      frames_out <= 8'h00;
      cnt_q <= 2'h0;
      dest_q <= 16'h0000;
    end else if (air_valid_in && air_ready_out) begin
      if (air_sof_in) begin
        dest_q <= {8'h00, air_data_in};
        cnt_q <= 2'h1;
      end else if (cnt_q == 2'h1) begin
        dest_q <= {dest_q[7:0], air_data_in};
        cnt_q <= 2'h2;
      end
      if (air_eof_in && dest_q == LOCAL) begin
        frames_out <= frames_out + 8'h01;
      end
    end
  end
endmodule // rcms_remote_model

// [testbench/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 0, sys_rst_in = 1, ce_in = 1, stall = 1, slow = 0;
  logic avs_read_in = 0, avs_write_in = 0, avs_waitrequest_out;
  logic [2:0] avs_address_in = 0, mode_out;
  logic [31:0] avs_writedata_in = 0, avs_readdata_out;
  logic cmd_valid_in = 0, cmd_ready_out, rsp_valid_out, rsp_ready_in = 1;
  logic [7:0] cmd_data_in = 0, rsp_data_out, ser_data_in = 0;
  logic [7:0] air_data_out, frames;
  logic byte_tick_in = 0, ser_valid_in = 0, ser_ready_out, air_valid_out;
  logic air_sof_out, air_eof_out, air_ready_in, rx_valid_in = 0, rxv_q = 0;
  logic [15:0] rx_dest_in = 0, link_rate_out, ra;
  logic rx_accept_out, fec_on_out, echk_on_out, crc_on_out;
  logic [31:0] rq[$], sq[$], aq[$], xq[$];
  integer seed = 87, bad_count = 0, num_checks = 0, em = 0, n, acc;
  rcms_top #(.DEPTH(8)) dut (.clk_sys_in, .sys_rst_in, .ce_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_readdata_out, .avs_waitrequest_out, .cmd_valid_in, .cmd_data_in,
    .cmd_ready_out, .rsp_valid_out, .rsp_data_out, .rsp_ready_in,
    .byte_tick_in, .ser_valid_in, .ser_data_in, .ser_ready_out,
    .air_valid_out, .air_data_out, .air_sof_out, .air_eof_out,
    .air_ready_in, .rx_valid_in, .rx_dest_in, .rx_accept_out, .mode_out,
    .fec_on_out, .echk_on_out, .crc_on_out, .link_rate_out);
  rcms_remote_model #(.LOCAL(16'h0042)) u_remote (.clk_sys_in,
    .sys_rst_in, .stall_in(stall), .slow_in(slow),
    .air_valid_in(air_valid_out), .air_data_in(air_data_out),
    .air_sof_in(air_sof_out), .air_eof_in(air_eof_out),
    .air_ready_out(air_ready_in), .frames_out(frames));
  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    rsp_ready_in <= $random(seed);
    byte_tick_in <= ($random(seed) & 3) == 0;
    rxv_q <= rx_valid_in;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (e !== g) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  always @(posedge clk_sys_in) begin
    if (avs_read_in && avs_waitrequest_out === 1'b0)
      chk("readdata", rq.pop_front(), avs_readdata_out);
    if (rsp_valid_out === 1'b1 && rsp_ready_in)
      chk("reply", sq.pop_front(), {24'h00_0000, rsp_data_out});
    if (air_valid_out === 1'b1 && air_ready_in)
      chk("air", aq.pop_front(), {air_sof_out, air_eof_out, air_data_out});
    if (rxv_q)
      chk("accept", xq.pop_front(), {31'h0000_0000, rx_accept_out});
  end
  task automatic avs(input logic w, input logic [2:0] a, [31:0] d);
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= !w;
    do @(posedge clk_sys_in);
    while (avs_waitrequest_out !== 1'b0);
    avs_write_in <= 0;
    avs_read_in <= 0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    rq.push_back(e);
    avs(0, a, 32'h0000_0000);
  endtask
  task automatic cmd(input logic [7:0] b);
    @(posedge clk_sys_in);
    cmd_valid_in <= 1;
    cmd_data_in <= b;
    do @(posedge clk_sys_in);
    while (cmd_ready_out !== 1'b1);
    cmd_valid_in <= 0;
  endtask
  task automatic drain;
    n = 0;
    while ((sq.size() || aq.size()) && n < 4000) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n >= 4000) bad_count++;
  endtask
  task automatic setm(input integer m);
    string s;
    s = m <= 5 ? "OK\015" : "ERROR\015";
    if (m <= 5) em = m;
    foreach (s[i]) sq.push_back(s[i]);
    cmd(8'h3d);
    cmd(8'h30 + 8'(m));
    cmd(8'h0d);
    drain;
  endtask
  function automatic logic [31:0] rate(integer m, w);
    if (m == 1) return w ? 32'h0000_4b00 : 32'h0000_2580;
    if (m == 2 || m == 3) return w ? 32'h0000_2580 : 32'h0000_12c0;
    return 32'h0000_0000;
  endfunction
  initial begin
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 0;
    rd(0, 32'h0000_0000);
    rd(2, 32'h0000_00ff);
    rd(3, 32'h0000_0000);
    rd(1, 32'h0000_0000);
    avs(1, 5, $random(seed));
    rd(5, 32'h0000_0000);
    rd(6, 32'h0000_0000);
    $display("test reset done");
    for (int w = 1; w >= 0; w--) begin
      avs(1, 0, 32'h0000_001c | (w << 6));
      for (int m = 0; m < 8; m++) begin
        setm(m);
        sq.push_back(8'h30 + 8'(em));
        sq.push_back(8'h0d);
        cmd(8'h3f);
        drain;
        rd(1, {em == 0, em == 0, em != 3, em[2:0]});
        rd(5, rate(em, w));
      end
    end
    $display("test modes done");
    ra = 16'($random(seed)) | 16'h8000;
    avs(1, 3, {16'h0000, ra});
    avs(1, 0, 32'h0000_0002);
    for (int k = 0; k < 12; k++) begin
      if (k % 6 == 0) setm(k == 0 ? 0 : 3);
      rx_dest_in <= k % 3 == 0 ? ra : k % 3 == 1 ? 16'h00ff : ra ^ 16'h0001;
      xq.push_back(em == 3 || k % 3 != 2);
      @(posedge clk_sys_in);
      rx_valid_in <= 1;
      @(posedge clk_sys_in);
      rx_valid_in <= 0;
    end
    $display("test receive filter done");
    setm(0);
    avs(1, 2, 32'h0000_0042);
    avs(1, 0, 32'h0000_0001);
    aq.push_back(32'h0000_0200);
    aq.push_back(32'h0000_0042);
    acc = 0;
    n = 0;
    ser_valid_in <= 1;
    ser_data_in <= $random(seed);
    while (n < 4 && acc < 40) begin
      @(posedge clk_sys_in);
      n++;
      if (ser_ready_out === 1'b1) begin
        aq.push_back({24'h00_0000, ser_data_in});
        ser_data_in <= $random(seed);
        acc++;
        n = 0;
      end
    end
    ser_valid_in <= 0;
    chk("buffer fill", 1, acc >= 8 && acc < 40);
    aq.push_back(32'h0000_0100);
    stall <= 0;
    slow <= 1;
    drain;
    repeat (8) @(posedge clk_sys_in);
    chk("remote frames", 1, frames);
    $display("test transmit done");
    ce_in <= 0;
    rx_dest_in <= 16'h00ff;
    xq.push_back(0);
    @(posedge clk_sys_in);
    rx_valid_in <= 1;
    @(posedge clk_sys_in);
    rx_valid_in <= 0;
    @(posedge clk_sys_in);
    ce_in <= 1;
    repeat (2) @(posedge clk_sys_in);
    $display("test clock enable done");
    chk("left over", 0, aq.size() + sq.size() + xq.size()
      + rq.size());
    final_report;
  end
  initial begin
    #3_000_000;
    bad_count++;
    final_report;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
endmodule // tb
bind rcms_top rcms_sva u_sva (.clk_sys_in, .sys_rst_in, .ce_in,
  .rx_valid_in, .rx_dest_in, .rx_accept_out, .rsp_ready_in, .rsp_valid_out,
  .rsp_data_out, .cmd_ready_out, .air_valid_out, .air_data_out,
  .air_sof_out, .air_eof_out, .mode_out, .fec_on_out, .echk_on_out,
  .crc_on_out, .link_rate_out);
